//--- rtl/aco_map.svh
// offsets, field positions, reset values and opcodes of the add/and core
// assumes inclusion by bare name from the core package users
`ifndef ACO_MAP_SVH
`define ACO_MAP_SVH

// register port offsets
`define ACO_REG_ACC      4'h0
`define ACO_REG_FLAGS    4'h1
`define ACO_REG_BANK     4'h2
`define ACO_REG_CTRL     4'h3
`define ACO_REG_IDX_LO   4'h4
`define ACO_REG_IDX_HI   4'h5
`define ACO_REG_STATE    4'h6

// flag bit positions
`define ACO_FLAG_C       0
`define ACO_FLAG_DC      1
`define ACO_FLAG_Z       2
`define ACO_FLAG_OV      3
`define ACO_FLAG_N       4

// control bit positions
`define ACO_CTRL_EXT     0

// instruction fields
`define ACO_INSTR_D      9
`define ACO_INSTR_A      8
`define ACO_OPC6_ADD     6'h09
`define ACO_OPC6_ADDC    6'h08
`define ACO_OPC8_ANDL    8'h0b

// addressing limits
`define ACO_IDX_LIMIT    8'h5f
`define ACO_SPLIT_STD    8'h80
`define ACO_SPLIT_EXT    8'h60
`define ACO_ACCESS_HI    4'hf
`define ACO_ACCESS_LO    4'h0

// reset values
`define ACO_RST_ACC      8'h00
`define ACO_RST_FLAGS    5'h00
`define ACO_RST_BANK     4'h0
`define ACO_RST_CTRL     1'b0
`define ACO_RST_IDX      12'h000

`endif

//--- rtl/aco_pkg.sv
// types of the add/and execution core
// assumes nothing beyond a SystemVerilog compiler
package aco_pkg;

	typedef enum logic [1:0]
	{
		ACO_PH_DECODE  = 2'b00,
		ACO_PH_READ    = 2'b01,
		ACO_PH_PROCESS = 2'b10,
		ACO_PH_WRITE   = 2'b11
	} aco_phase_type;

	typedef enum logic [1:0]
	{
		ACO_OP_NONE = 2'b00,
		ACO_OP_ADD  = 2'b01,
		ACO_OP_ADDC = 2'b10,
		ACO_OP_ANDL = 2'b11
	} aco_op_type;

endpackage : aco_pkg

//--- rtl/aco_addr.sv
// file address resolver: access bank, banked and indexed literal offset
// assumes bank, control and index base are stable during decode
`include "aco_map.svh"

module aco_addr
(
	input  wire logic [7:0]  file_addr,
	input  wire logic        access_sel,
	input  wire logic [3:0]  bank_sel,
	input  wire logic        ext_enable,
	input  wire logic [11:0] index_base,
	output logic      [11:0] data_addr,
	output logic             indexed
);

	logic [7:0] split;

	always_comb
	begin
		split = ext_enable ? `ACO_SPLIT_EXT : `ACO_SPLIT_STD;
		indexed = 1'b0;
		if (!access_sel && ext_enable && file_addr <= `ACO_IDX_LIMIT)
		begin
			indexed = 1'b1;
			data_addr = index_base + {4'h0, file_addr};
		end
		else if (access_sel)
			data_addr = {bank_sel, file_addr};
		else if (file_addr < split)
			data_addr = {`ACO_ACCESS_LO, file_addr};
		else
			data_addr = {`ACO_ACCESS_HI, file_addr};
	end

endmodule : aco_addr

//--- rtl/aco_core.sv
// add, add-with-carry and and-literal execution core, four phases an instruction
// assumes a data memory that answers a read in the cycle its address stands
//
// Summary of operation
// - add-with-carry adds acc, memory byte and carry, sets N OV C DC Z.
// - destination bit 0 sends the sum to acc, bit 1 back to memory.
// - access bit 0 resolves in the access bank, 1 uses the bank select.
// - access bit 0, extended set on and f up to 95 select indexed mode.
`include "aco_map.svh"

module aco_core
(
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [15:0] INSTR,
	input  wire logic        INSTR_VALID,
	output logic             INSTR_REQ,
	output logic             EXEC_DONE,
	output logic [11:0]      MEM_ADDR,
	output logic [7:0]       MEM_WDATA,
	output logic             MEM_WE,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [7:0]       REG_RDATA,
	output logic [7:0]       ACC_VALUE,
	output logic [4:0]       FLAGS
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic                  rst_meta_q;
	logic                  rst_sync_q;
	aco_pkg::aco_phase_type ph_q;
	aco_pkg::aco_op_type   op_q;
	aco_pkg::aco_op_type   op_dec;
	logic                  dest_file_q;
	logic [7:0]            lit_q;
	logic [7:0]            opnd_q;
	logic [7:0]            res_q;
	logic [4:0]            new_flags_q;
	logic [7:0]            acc_q;
	logic [4:0]            flags_q;
	logic [3:0]            bank_q;
	logic                  ext_q;
	logic [11:0]           idx_q;
	logic                  idx_used_q;
	logic [11:0]           mem_addr_q;
	logic [7:0]            mem_wdata_q;
	logic                  mem_we_q;
	logic                  req_q;
	logic                  done_q;
	logic [7:0]            rdata_q;
	logic [11:0]           res_addr;
	logic                  res_indexed;
	logic [8:0]            sum9;
	logic [4:0]            sum_lo;
	logic                  cin;
	logic [7:0]            result_d;
	logic [4:0]            flags_d;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic aco_pkg::aco_op_type decode_op
	(
		input logic        valid,
		input logic [15:0] word
	);
		aco_pkg::aco_op_type op;
		op = aco_pkg::ACO_OP_NONE;
		if (valid)
		begin
			if (word[15:10] == `ACO_OPC6_ADD)
				op = aco_pkg::ACO_OP_ADD;
			else if (word[15:10] == `ACO_OPC6_ADDC)
				op = aco_pkg::ACO_OP_ADDC;
			else if (word[15:8] == `ACO_OPC8_ANDL)
				op = aco_pkg::ACO_OP_ANDL;
		end
		return op;
	endfunction : decode_op

	function automatic logic sw_write
	(
		input logic       wr,
		input logic [3:0] addr,
		input logic [3:0] target
	);
		return wr && (addr == target);
	endfunction : sw_write

	////////////////////////////////////////////////////////////////////////
	// reset release

	// assert at once, release through two flops to avoid a ragged exit
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phase sequencer: one instruction per four clocks

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			ph_q <= aco_pkg::ACO_PH_DECODE;
		else
		begin
			unique case (ph_q)
				aco_pkg::ACO_PH_DECODE:  ph_q <= aco_pkg::ACO_PH_READ;
				aco_pkg::ACO_PH_READ:    ph_q <= aco_pkg::ACO_PH_PROCESS;
				aco_pkg::ACO_PH_PROCESS: ph_q <= aco_pkg::ACO_PH_WRITE;
				aco_pkg::ACO_PH_WRITE:   ph_q <= aco_pkg::ACO_PH_DECODE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			req_q  <= 1'b1;
			done_q <= 1'b0;
		end
		else
		begin
			req_q  <= (ph_q == aco_pkg::ACO_PH_WRITE);
			done_q <= (ph_q == aco_pkg::ACO_PH_WRITE) &&
				(op_q != aco_pkg::ACO_OP_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decode and address

	assign op_dec = decode_op(INSTR_VALID, INSTR);

	aco_addr u_addr
	(
		.file_addr  (INSTR[7:0]),
		.access_sel (INSTR[`ACO_INSTR_A]),
		.bank_sel   (bank_q),
		.ext_enable (ext_q),
		.index_base (idx_q),
		.data_addr  (res_addr),
		.indexed    (res_indexed)
	);

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			op_q        <= aco_pkg::ACO_OP_NONE;
			dest_file_q <= 1'b0;
			lit_q       <= 8'h00;
			mem_addr_q  <= 12'h000;
			idx_used_q  <= 1'b0;
		end
		else if (ph_q == aco_pkg::ACO_PH_DECODE)
		begin
			op_q        <= op_dec;
			dest_file_q <= INSTR[`ACO_INSTR_D];
			lit_q       <= INSTR[7:0];
			if (op_dec == aco_pkg::ACO_OP_ADD ||
				op_dec == aco_pkg::ACO_OP_ADDC)
			begin
				mem_addr_q <= res_addr;
				idx_used_q <= res_indexed;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operand read

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			opnd_q <= 8'h00;
		else if (ph_q == aco_pkg::ACO_PH_READ)
			opnd_q <= (op_q == aco_pkg::ACO_OP_ANDL) ? lit_q : MEM_RDATA;
	end

	////////////////////////////////////////////////////////////////////////
	// process: arithmetic and flags

	always_comb
	begin
		cin = (op_q == aco_pkg::ACO_OP_ADDC) && flags_q[`ACO_FLAG_C];
		sum9 = {1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, cin};
		sum_lo = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cin};
		flags_d = flags_q;
		if (op_q == aco_pkg::ACO_OP_ANDL)
		begin
			result_d = acc_q & opnd_q;
		end
		else
		begin
			result_d = sum9[7:0];
			flags_d[`ACO_FLAG_C]  = sum9[8];
			flags_d[`ACO_FLAG_DC] = sum_lo[4];
			flags_d[`ACO_FLAG_OV] = (acc_q[7] == opnd_q[7]) &&
				(sum9[7] != acc_q[7]);
		end
		// and-literal leaves C, DC and OV as they were
		flags_d[`ACO_FLAG_N] = result_d[7];
		flags_d[`ACO_FLAG_Z] = (result_d == 8'h00);
	end

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			res_q       <= 8'h00;
			new_flags_q <= `ACO_RST_FLAGS;
		end
		else if (ph_q == aco_pkg::ACO_PH_PROCESS)
		begin
			res_q       <= result_d;
			new_flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write to destination

	// the memory write strobe stands only for the write phase
	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			mem_we_q    <= 1'b0;
			mem_wdata_q <= 8'h00;
		end
		else if (ph_q == aco_pkg::ACO_PH_PROCESS)
		begin
			mem_we_q <= dest_file_q &&
				(op_q == aco_pkg::ACO_OP_ADD ||
				op_q == aco_pkg::ACO_OP_ADDC);
			mem_wdata_q <= result_d;
		end
		else
			mem_we_q <= 1'b0;
	end

	// an instruction result beats a software write in the same cycle
	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			acc_q <= `ACO_RST_ACC;
		else if (ph_q == aco_pkg::ACO_PH_WRITE &&
			(op_q == aco_pkg::ACO_OP_ANDL ||
			(op_q != aco_pkg::ACO_OP_NONE && !dest_file_q)))
			acc_q <= res_q;
		else if (sw_write(REG_WR, REG_ADDR, `ACO_REG_ACC))
			acc_q <= REG_WDATA;
	end

	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			flags_q <= `ACO_RST_FLAGS;
		else if (ph_q == aco_pkg::ACO_PH_WRITE &&
			op_q != aco_pkg::ACO_OP_NONE)
			flags_q <= new_flags_q;
		else if (sw_write(REG_WR, REG_ADDR, `ACO_REG_FLAGS))
			flags_q <= REG_WDATA[4:0];
	end

	////////////////////////////////////////////////////////////////////////
	// addressing configuration

	// changes take effect at the next decode phase
	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			bank_q <= `ACO_RST_BANK;
			ext_q  <= `ACO_RST_CTRL;
			idx_q  <= `ACO_RST_IDX;
		end
		else
		begin
			if (sw_write(REG_WR, REG_ADDR, `ACO_REG_BANK))
				bank_q <= REG_WDATA[3:0];
			if (sw_write(REG_WR, REG_ADDR, `ACO_REG_CTRL))
				ext_q <= REG_WDATA[`ACO_CTRL_EXT];
			if (sw_write(REG_WR, REG_ADDR, `ACO_REG_IDX_LO))
				idx_q[7:0] <= REG_WDATA;
			if (sw_write(REG_WR, REG_ADDR, `ACO_REG_IDX_HI))
				idx_q[11:8] <= REG_WDATA[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read port

	// data stand one cycle only, zero otherwise
	always_ff @(posedge CLK_SYS or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rdata_q <= 8'h00;
		else if (REG_RD)
		begin
			unique case (REG_ADDR)
				`ACO_REG_ACC:    rdata_q <= acc_q;
				`ACO_REG_FLAGS:  rdata_q <= {3'h0, flags_q};
				`ACO_REG_BANK:   rdata_q <= {4'h0, bank_q};
				`ACO_REG_CTRL:   rdata_q <= {7'h00, ext_q};
				`ACO_REG_IDX_LO: rdata_q <= idx_q[7:0];
				`ACO_REG_IDX_HI: rdata_q <= {4'h0, idx_q[11:8]};
				`ACO_REG_STATE:  rdata_q <= {3'h0, idx_used_q, op_q, ph_q};
				default:         rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign INSTR_REQ = req_q;
	assign EXEC_DONE = done_q;
	assign MEM_ADDR  = mem_addr_q;
	assign MEM_WDATA = mem_wdata_q;
	assign MEM_WE    = mem_we_q;
	assign REG_RDATA = rdata_q;
	assign ACC_VALUE = acc_q;
	assign FLAGS     = flags_q;

endmodule : aco_core

//--- testbench/aco_core_properties.sv
// port checks of the add/and core
// assumes bind onto aco_core, one clock domain, async low reset
module aco_core_properties
(
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic [15:0] INSTR,
	input wire logic        INSTR_VALID,
	input wire logic        INSTR_REQ,
	input wire logic        EXEC_DONE,
	input wire logic [11:0] MEM_ADDR,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic        MEM_WE,
	input wire logic [7:0]  MEM_RDATA,
	input wire logic [7:0]  ACC_VALUE,
	input wire logic [4:0]  FLAGS
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
////////////////////////////////////////////////////////////
	sequence s_add;
		INSTR_REQ && INSTR_VALID && INSTR[15:11] == 5'h04;
	endsequence
	sequence s_addc;
		s_add ##0 !INSTR[10];
	endsequence
	sequence s_and;
		INSTR_REQ && INSTR_VALID && INSTR[15:8] == 8'h0b;
	endsequence
	// memory data is sampled in the read phase, carry at decode
	chk_done_timing: assert property
		(s_add |=> !EXEC_DONE [*3] ##1 EXEC_DONE)
		else $error("done pulse misplaced");
	chk_carry_sum: assert property
		(s_addc ##0 !INSTR[9] |-> ##4 ACC_VALUE == 8'($past(ACC_VALUE, 4)
		+ $past(MEM_RDATA, 3) + $past(FLAGS[0], 4)))
		else $error("sum into accumulator wrong");
	chk_write_back: assert property
		(s_addc ##0 INSTR[9] |-> ##3 MEM_WE && MEM_WDATA ==
		8'($past(ACC_VALUE, 3) + $past(MEM_RDATA, 2) + $past(FLAGS[0], 3)))
		else $error("sum to memory wrong");
	chk_acc_dest: assert property
		(s_add ##0 !INSTR[9] |=> !MEM_WE [*3])
		else $error("memory written for accumulator result");
	chk_bank_addr: assert property
		(s_add ##0 (INSTR[8] || INSTR[7]) |=>
		MEM_ADDR[7:0] == $past(INSTR[7:0]) &&
		($past(INSTR[8]) || MEM_ADDR[11:8] == 4'hf))
		else $error("file address resolved wrong");
	chk_and_value: assert property
		(s_and |=> !MEM_WE [*3] ##1 EXEC_DONE &&
		ACC_VALUE == ($past(ACC_VALUE, 4) & $past(INSTR[7:0], 4)))
		else $error("and result wrong");
	chk_and_flags: assert property
		(s_and |-> ##4 FLAGS[3] == $past(FLAGS[3], 4) &&
		FLAGS[1:0] == $past(FLAGS[1:0], 4) &&
		FLAGS[2] == (ACC_VALUE == 8'h00) && FLAGS[4] == ACC_VALUE[7])
		else $error("and flags wrong");
endmodule : aco_core_properties
////////////////////////////////////////////////////////////
bind aco_core aco_core_properties chk
(
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
	.INSTR_REQ(INSTR_REQ), .EXEC_DONE(EXEC_DONE), .MEM_ADDR(MEM_ADDR),
	.MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RDATA(MEM_RDATA),
	.ACC_VALUE(ACC_VALUE), .FLAGS(FLAGS)
);

//--- testbench/test_add_carry_and_logic_ops.sv
// bench of the add/and core: instruction table, then odd cases
// assumes four-cycle slots and register reads answered next cycle
module test_add_carry_and_logic_ops;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [15:0] w; logic [7:0] m; logic [11:0] ea;
		logic we; logic [7:0] r; logic [4:0] fl; logic [7:0] acc;} aco_row_type;
	logic        CLK_SYS = 1'b0, RST_N = 1'b0, INSTR_VALID = 1'b0;
	logic        REG_WR = 1'b0, REG_RD = 1'b0, INSTR_REQ, EXEC_DONE, MEM_WE;
	logic [15:0] INSTR = 16'h0000;
	logic [7:0]  MEM_RDATA = 8'h00, REG_WDATA = 8'h00;
	logic [3:0]  REG_ADDR = 4'h0;
	logic [11:0] MEM_ADDR;
	logic [7:0]  MEM_WDATA, REG_RDATA, ACC_VALUE;
	logic [4:0]  FLAGS;
	int          n_fail = 0, total_checks = 0, i;
	// chained: each row starts from the state the previous row left
	aco_row_type rows [8] = '{
		'{16'h2410, 8'hc2, 12'h010, 1'b0, 8'h00, 5'h10, 8'hd9},
		'{16'h2385, 8'h27, 12'h385, 1'b1, 8'h00, 5'h07, 8'hd9},
		'{16'h20a0, 8'h26, 12'hfa0, 1'b0, 8'h00, 5'h07, 8'h00},
		'{16'h207f, 8'h7f, 12'h07f, 1'b0, 8'h00, 5'h1a, 8'h80},
		'{16'h0b5f, 8'h00, 12'h000, 1'b0, 8'h00, 5'h0e, 8'h00},
		'{16'h225f, 8'h01, 12'h17f, 1'b1, 8'h01, 5'h00, 8'h00},
		'{16'h2660, 8'h00, 12'hf60, 1'b1, 8'h00, 5'h04, 8'h00},
		'{16'h275f, 8'h05, 12'h35f, 1'b1, 8'h05, 5'h00, 8'h00}};
	aco_core dut
	(
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR(INSTR),
		.INSTR_VALID(INSTR_VALID), .INSTR_REQ(INSTR_REQ), .EXEC_DONE(EXEC_DONE),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE),
		.MEM_RDATA(MEM_RDATA), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.ACC_VALUE(ACC_VALUE), .FLAGS(FLAGS)
	);
	always #25 CLK_SYS = ~CLK_SYS;
////////////////////////////////////////////////////////////
	task check(input string nm, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : check
	task test_done;
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		@(negedge CLK_SYS);
		check("reg", {8'h00, REG_RDATA}, {8'h00, e});
	endtask : reg_rd
	// word is held until a decode cycle takes it; memory data held too
	task exec(input aco_row_type t);
		int n;
		@(posedge CLK_SYS);
		INSTR <= t.w;
		INSTR_VALID <= 1'b1;
		MEM_RDATA <= t.m;
		// look half a cycle on: in the launching edge the request is stale
		@(negedge CLK_SYS);
		for (n = 0; n < 8 && INSTR_REQ !== 1'b1; n++)
			@(negedge CLK_SYS);
		if (INSTR_REQ !== 1'b1)
		begin
			n_fail++;
			test_done();
		end
		@(posedge CLK_SYS);
		INSTR_VALID <= 1'b0;
		@(negedge CLK_SYS);
		if (t.w[15:12] == 4'h2)
			check("addr", {4'h0, MEM_ADDR}, {4'h0, t.ea});
		repeat (2) @(negedge CLK_SYS);
		check("we", {15'h0000, MEM_WE}, {15'h0000, t.we});
		if (t.we)
			check("wdata", {8'h00, MEM_WDATA}, {8'h00, t.r});
		@(negedge CLK_SYS);
		check("done", {15'h0000, EXEC_DONE}, 16'h0001);
		check("acc", {8'h00, ACC_VALUE}, {8'h00, t.acc});
		check("flags", {11'h000, FLAGS}, {11'h000, t.fl});
	endtask : exec
////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		reg_wr(4'h2, 8'h03);
		reg_wr(4'h4, 8'h20);
		reg_wr(4'h5, 8'h01);
		reg_wr(4'h0, 8'h17);
		for (i = 0; i < 8; i++)
		begin
			if (i == 5)
				reg_wr(4'h3, 8'h01);
			exec(rows[i]);
		end
		// index base at the top of memory: offset must wrap to zero
		reg_wr(4'h4, 8'hff);
		reg_wr(4'h5, 8'h0f);
		exec('{16'h2201, 8'h00, 12'h000, 1'b1, 8'h00, 5'h04, 8'h00});
		reg_rd(4'h1, 8'h04);
		reg_rd(4'h2, 8'h03);
		reg_rd(4'h3, 8'h01);
		reg_rd(4'h5, 8'h0f);
		reg_rd(4'h0, 8'h00);
		reg_wr(4'h7, 8'h55);
		reg_rd(4'h7, 8'h00);
		reg_wr(4'h0, 8'h3c);
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		@(negedge CLK_SYS);
		check("rst acc", {8'h00, ACC_VALUE}, 16'h0000);
		check("rst req", {15'h0000, INSTR_REQ}, 16'h0001);
		@(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		reg_rd(4'h2, 8'h00);
		reg_rd(4'h3, 8'h00);
		test_done();
	end
endmodule : test_add_carry_and_logic_ops
